/* File: hdl/ctf_pkg.sv */
// constants and types for the can timing, filter and time stamp block
package ctf_pkg;
  localparam int NSLOT = 16;
  localparam int TS_W = 16;
  localparam int CATCH_A = 14;
  localparam int CATCH_B = 15;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIMING = 8'h04;
  localparam logic [7:0] OFF_CLKSEL = 8'h08;
  localparam logic [7:0] OFF_GMASK = 8'h0c;
  localparam logic [7:0] OFF_LMASK_A = 8'h10;
  localparam logic [7:0] OFF_LMASK_B = 8'h14;
  localparam logic [7:0] OFF_IDFMT = 8'h18;
  localparam logic [7:0] OFF_RXEN = 8'h1c;
  localparam logic [7:0] OFF_TS = 8'h20;
  localparam logic [7:0] OFF_AFS = 8'h24;
  localparam logic [7:0] OFF_ERR = 8'h28;
  localparam logic [7:0] OFF_STAT = 8'h2c;
  localparam logic [7:0] OFF_SLOT = 8'h40;
  localparam logic [28:0] STD_ID_MASK = 29'h000007ff;
  localparam logic [28:0] EXT_ID_MASK = 29'h1fffffff;
  localparam logic [2:0] CLKSEL_MAX = 3'h4;
  localparam logic [7:0] REC_MAX = 8'hff;
  localparam logic [8:0] TEC_MAX = 9'h100;

  typedef struct packed {
    logic [1:0] ts_div;
    logic       force_exit;
    logic       listen_only;
    logic       alt_en;
    logic       init_mode;
  } ctf_ctrl_t;

  // segment lengths are stored as length minus one
  typedef struct packed {
    logic [1:0] resync_jump_width;
    logic [2:0] pb2;
    logic [2:0] pb1;
    logic [2:0] prop;
    logic [3:0] baud_prescaler_field;
  } ctf_timing_t;

  localparam ctf_ctrl_t CTRL_RST = 6'h01;
  localparam ctf_timing_t TIMING_RST = 15'h0910;

  typedef enum logic [3:0] {
    SEG_SYNC = 4'h1,
    SEG_PROP = 4'h2,
    SEG_PB1  = 4'h4,
    SEG_PB2  = 4'h8
  } ctf_seg_t;

  typedef struct packed {
    ctf_ctrl_t               ctrl;
    ctf_timing_t             timing;
    logic [2:0]              clk_sel;
    logic [28:0]             gmask;
    logic [28:0]             lmask_a;
    logic [28:0]             lmask_b;
    logic [NSLOT-1:0]        id_fmt;
    logic [NSLOT-1:0]        rx_en;
    logic [NSLOT-1:0][28:0]  slot_id;
    logic [10:0]             afs_id;
    logic [7:0]              rec;
    logic [8:0]              tec;
    logic [9:0]              pre_cnt;
    ctf_seg_t                seg;
    logic [4:0]              tq_cnt;
    logic [4:0]              pb1_len;
    logic [4:0]              pb2_len;
    logic                    resynced;
    logic                    edge_pend;
    logic [1:0]              rx_sync;
    logic                    rx_prev;
    logic                    rx_bit;
    logic [2:0]              ts_pre;
    logic [TS_W-1:0]         ts;
    logic                    alt_sel;
    logic                    store_valid;
    logic [3:0]              store_slot;
    logic [TS_W-1:0]         store_stamp;
    logic                    sample_pulse;
    logic                    bit_pulse;
    logic                    reinit_pulse;
    logic                    tx;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } ctf_state_t;
endpackage

/* File: hdl/ctf_top.sv */
// can bit timing, acceptance filter, time stamp and apb registers
`timescale 1ns/1ps
module ctf_top (
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    can_rx,
  output logic                         can_tx,
  input  wire logic                    pe_tx_bit,
  input  wire logic                    rx_ok,
  input  wire logic [28:0]             rx_id,
  input  wire logic                    rx_ext,
  input  wire logic                    rx_err_inc,
  input  wire logic                    tx_err_inc,
  output logic                         bit_start,
  output logic                         sample_point,
  output logic                         rx_bit,
  output logic                         store_valid,
  output logic [3:0]                   store_slot,
  output logic [ctf_pkg::TS_W-1:0]     store_stamp,
  output logic                         pe_reinit,
  output logic                         bus_off
);
  ctf_pkg::ctf_state_t s;
  ctf_pkg::ctf_state_t next_s;
  logic [1:0]          rst_sync;
  logic                rst_n;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[7:6] == 2'b01) ||
              (a[7:6] == 2'b00 && a[5:2] <= ctf_pkg::OFF_STAT[5:2]);
  endfunction

  localparam int NSL = ctf_pkg::NSLOT;
  logic [NSL-1:0] hit;
  logic [28:0]    wmask;
  logic [28:0]    msk;
  logic [4:0]     low;
  logic [4:0]     prop_len;
  logic [4:0]     resync_jump_width;
  logic [4:0]     e_late;
  logic [4:0]     e_early;
  logic [4:0]     pb1_eff;
  logic [4:0]     pb2_eff;
  logic [2:0]     csel;
  logic [9:0]     reload;
  logic           tq_tick;
  logic           res;
  logic           fall;
  logic           acc;
  logic           done;
  logic           wr;
  logic [31:0]    rd;
  logic [2:0]     ts_top;

  // acceptance: per slot compare under its mask and format
  always_comb begin
    hit = '0;
    msk = '0;
    wmask = rx_ext ? ctf_pkg::EXT_ID_MASK : ctf_pkg::STD_ID_MASK;
    for (int n = 0; n < NSL; n++) begin
      if (n == ctf_pkg::CATCH_A)
        msk = s.lmask_a;
      else if (n == ctf_pkg::CATCH_B)
        msk = s.lmask_b;
      else
        msk = s.gmask;
      hit[n] = s.rx_en[n] && (s.id_fmt[n] == rx_ext) &&
               (((rx_id ^ s.slot_id[n]) & msk & wmask) == 29'h0);
    end
    low = 5'h10;
    for (int n = ctf_pkg::CATCH_A - 1; n >= 0; n--) begin
      if (hit[n])
        low = {1'b0, 4'(n)};
    end
  end

  always_comb begin
    rd = 32'h0;
    case (paddr[7:2])
      ctf_pkg::OFF_CTRL[7:2]:    rd[5:0] = s.ctrl;
      ctf_pkg::OFF_TIMING[7:2]:  rd[14:0] = s.timing;
      ctf_pkg::OFF_CLKSEL[7:2]:  rd[2:0] = s.clk_sel;
      ctf_pkg::OFF_GMASK[7:2]:   rd[28:0] = s.gmask;
      ctf_pkg::OFF_LMASK_A[7:2]: rd[28:0] = s.lmask_a;
      ctf_pkg::OFF_LMASK_B[7:2]: rd[28:0] = s.lmask_b;
      ctf_pkg::OFF_IDFMT[7:2]:   rd[15:0] = s.id_fmt;
      ctf_pkg::OFF_RXEN[7:2]:    rd[15:0] = s.rx_en;
      ctf_pkg::OFF_TS[7:2]:      rd[15:0] = s.ts;
      ctf_pkg::OFF_AFS[7:2]:     rd[15:0] = {s.afs_id[10:3],
                                   8'(8'h01 << s.afs_id[2:0])};
      ctf_pkg::OFF_ERR[7:2]:     rd[17:0] = {s.tec[8], s.tec, s.rec};
      ctf_pkg::OFF_STAT[7:2]:    rd[4:0] = {s.alt_sel, s.store_slot};
      default: begin
        if (paddr[7:6] == 2'b01)
          rd[28:0] = s.slot_id[paddr[5:2]];
      end
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.sample_pulse = 1'b0;
    next_s.bit_pulse = 1'b0;
    next_s.reinit_pulse = 1'b0;
    next_s.store_valid = 1'b0;

    // apb: one wait state, answer registered
    acc = psel && penable && !s.pready;
    done = psel && penable && s.pready;
    wr = done && pwrite && !s.pslverr;
    next_s.pready = acc;
    if (acc) begin
      next_s.pslverr = !addr_ok(paddr);
      next_s.prdata = pwrite ? 32'h0 : rd;
    end
    if (wr) begin
      case (paddr[7:2])
        ctf_pkg::OFF_CTRL[7:2]: begin
          next_s.ctrl = ctf_pkg::ctf_ctrl_t'(pwdata[5:0]);
          next_s.ctrl.force_exit = 1'b0;
        end
        ctf_pkg::OFF_TIMING[7:2]:  next_s.timing = pwdata[14:0];
        ctf_pkg::OFF_CLKSEL[7:2]:  next_s.clk_sel = pwdata[2:0];
        ctf_pkg::OFF_GMASK[7:2]:   next_s.gmask = pwdata[28:0];
        ctf_pkg::OFF_LMASK_A[7:2]: next_s.lmask_a = pwdata[28:0];
        ctf_pkg::OFF_LMASK_B[7:2]: next_s.lmask_b = pwdata[28:0];
        ctf_pkg::OFF_IDFMT[7:2]:   next_s.id_fmt = pwdata[15:0];
        ctf_pkg::OFF_RXEN[7:2]:    next_s.rx_en = pwdata[15:0];
        ctf_pkg::OFF_AFS[7:2]:     next_s.afs_id = pwdata[10:0];
        default: begin
          if (paddr[7:6] == 2'b01)
            next_s.slot_id[paddr[5:2]] = pwdata[28:0];
        end
      endcase
    end

    // error counters saturate; tec reaching 256 is bus off
    if (rx_err_inc && s.rec != ctf_pkg::REC_MAX)
      next_s.rec = s.rec + 8'h01;
    if (tx_err_inc && s.tec != ctf_pkg::TEC_MAX)
      next_s.tec = s.tec + 9'h001;
    if (wr && paddr[7:2] == ctf_pkg::OFF_CTRL[7:2] && pwdata[3]) begin
      next_s.rec = 8'h00;
      next_s.tec = 9'h000;
      next_s.reinit_pulse = 1'b1;
    end

    csel = (s.clk_sel > ctf_pkg::CLKSEL_MAX) ? ctf_pkg::CLKSEL_MAX
                                             : s.clk_sel;
    // quantum = 2 * div * prescale
    reload = 10'((10'(s.timing.baud_prescaler_field) + 10'd1) << (csel + 3'd1)) - 10'd1;
    tq_tick = !s.ctrl.init_mode && (s.pre_cnt == reload);
    next_s.pre_cnt = (tq_tick || s.ctrl.init_mode) ? 10'h0
                                                   : s.pre_cnt + 10'h1;

    // synchroniser; only stage two is looked at
    next_s.rx_sync = {s.rx_sync[0], can_rx};
    next_s.rx_prev = s.rx_sync[1];
    fall = s.rx_prev && !s.rx_sync[1];
    // falling edge kept until next quantum
    next_s.edge_pend = (s.edge_pend && !tq_tick) || fall;

    prop_len = 5'(s.timing.prop) + 5'd1;
    resync_jump_width = 5'(s.timing.resync_jump_width) + 5'd1;
    e_late = (s.seg == ctf_pkg::SEG_PROP) ? s.tq_cnt + 5'd1
                                          : prop_len + s.tq_cnt + 5'd1;
    e_early = s.pb2_len - s.tq_cnt;
    // a single correction per bit, as edges in sync need none
    res = tq_tick && s.edge_pend && !s.resynced;
    pb1_eff = s.pb1_len + ((e_late < resync_jump_width) ? e_late : resync_jump_width);
    pb2_eff = s.pb2_len - resync_jump_width;
    if (s.ctrl.init_mode) begin
      next_s.seg = ctf_pkg::SEG_SYNC;
      next_s.tq_cnt = 5'h0;
      next_s.resynced = 1'b0;
    end else if (tq_tick) begin
      case (s.seg)
        ctf_pkg::SEG_SYNC: begin
          next_s.seg = ctf_pkg::SEG_PROP;
          next_s.tq_cnt = 5'h0;
          next_s.pb1_len = 5'(s.timing.pb1) + 5'd1;
          next_s.pb2_len = 5'(s.timing.pb2) + 5'd1;
          next_s.resynced = 1'b0;
        end
        ctf_pkg::SEG_PROP: begin
          if (res) begin
            next_s.pb1_len = pb1_eff;
            next_s.resynced = 1'b1;
          end
          if (s.tq_cnt + 5'd1 >= prop_len) begin
            next_s.seg = ctf_pkg::SEG_PB1;
            next_s.tq_cnt = 5'h0;
          end else
            next_s.tq_cnt = s.tq_cnt + 5'd1;
        end
        ctf_pkg::SEG_PB1: begin
          if (res) begin
            next_s.pb1_len = pb1_eff;
            next_s.resynced = 1'b1;
          end
          if (s.tq_cnt + 5'd1 >= (res ? pb1_eff : s.pb1_len)) begin
            next_s.seg = ctf_pkg::SEG_PB2;
            next_s.tq_cnt = 5'h0;
            next_s.sample_pulse = 1'b1;
            next_s.rx_bit = s.rx_sync[1];
          end else
            next_s.tq_cnt = s.tq_cnt + 5'd1;
        end
        ctf_pkg::SEG_PB2: begin
          if (res)
            next_s.resynced = 1'b1;
          if (res && e_early > resync_jump_width)
            next_s.pb2_len = pb2_eff;
          if ((res && e_early <= resync_jump_width) ||
              (s.tq_cnt + 5'd1 >= (res ? pb2_eff : s.pb2_len))) begin
            next_s.seg = ctf_pkg::SEG_SYNC;
            next_s.tq_cnt = 5'h0;
            next_s.bit_pulse = 1'b1;
          end else
            next_s.tq_cnt = s.tq_cnt + 5'd1;
        end
        default: begin
          next_s.seg = ctf_pkg::SEG_SYNC;
          next_s.tq_cnt = 5'h0;
        end
      endcase
    end

    ts_top = 3'(4'h1 << s.ctrl.ts_div) - 3'd1;
    if (tq_tick && s.seg == ctf_pkg::SEG_SYNC) begin
      if (s.ts_pre >= ts_top) begin
        next_s.ts_pre = 3'h0;
        next_s.ts = s.ts + 16'h0001;
      end else
        next_s.ts_pre = s.ts_pre + 3'h1;
    end

    if (rx_ok && hit != '0) begin
      next_s.store_valid = 1'b1;
      next_s.store_stamp = s.ts;
      if (!low[4])
        next_s.store_slot = low[3:0];
      else if (s.ctrl.alt_en) begin
        if ((s.alt_sel && hit[ctf_pkg::CATCH_B]) ||
            !hit[ctf_pkg::CATCH_A])
          next_s.store_slot = 4'(ctf_pkg::CATCH_B);
        else
          next_s.store_slot = 4'(ctf_pkg::CATCH_A);
        next_s.alt_sel = !s.alt_sel;
      end else if (hit[ctf_pkg::CATCH_A])
        next_s.store_slot = 4'(ctf_pkg::CATCH_A);
      else
        next_s.store_slot = 4'(ctf_pkg::CATCH_B);
    end

    next_s.tx = (s.ctrl.listen_only || s.ctrl.init_mode) ? 1'b1
                                                          : pe_tx_bit;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= ctf_pkg::CTRL_RST;
      s.timing <= ctf_pkg::TIMING_RST;
      s.seg <= ctf_pkg::SEG_SYNC;
      s.rx_sync <= 2'b11;
      s.rx_prev <= 1'b1;
      s.rx_bit <= 1'b1;
      s.tx <= 1'b1;
    end else
      s <= next_s;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign can_tx = s.tx;
  assign bit_start = s.bit_pulse;
  assign sample_point = s.sample_pulse;
  assign rx_bit = s.rx_bit;
  assign store_valid = s.store_valid;
  assign store_slot = s.store_slot;
  assign store_stamp = s.store_stamp;
  assign pe_reinit = s.reinit_pulse;
  assign bus_off = s.tec[8];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sync_one_tq_a: assert property (
    tq_tick && s.seg == ctf_pkg::SEG_SYNC |=> s.seg == ctf_pkg::SEG_PROP)
    else $error("sync segment not one quantum");
  listen_quiet_a: assert property (
    s.ctrl.listen_only |=> can_tx)
    else $error("bus driven in listen-only");
  exit_clear_a: assert property (
    wr && paddr[7:2] == ctf_pkg::OFF_CTRL[7:2] && pwdata[3]
    |=> s.rec == 8'h00 && s.tec == 9'h000 && pe_reinit)
    else $error("bus-off exit did not clear counters");
  exit_keep_a: assert property (
    wr && paddr[7:2] == ctf_pkg::OFF_CTRL[7:2] && pwdata[3]
    |=> $stable(s.timing) && $stable(s.slot_id))
    else $error("bus-off exit altered configuration");
  prescale_a: assert property (
    tq_tick |-> $past(s.pre_cnt, 1) == reload - 10'd1)
    else $error("quantum prescaler period wrong");
  low_slot_a: assert property (
    rx_ok && hit[0] |=> store_valid && store_slot == 4'h0)
    else $error("slot 0 match not stored in slot 0");
  stamp_cap_a: assert property (
    rx_ok && hit != '0 |=> store_stamp == $past(s.ts))
    else $error("stamp not captured at reception");
  alt_toggle_a: assert property (
    rx_ok && low[4] && hit[15:14] == 2'b11 && s.ctrl.alt_en
    |=> s.alt_sel != $past(s.alt_sel) && store_slot[3:1] == 3'b111)
    else $error("alternate slot selection did not toggle");
  early_end_a: assert property (
    res && s.seg == ctf_pkg::SEG_PB2 && e_early <= resync_jump_width
    |=> bit_start ##1 s.seg == ctf_pkg::SEG_SYNC)
    else $error("early edge did not end phase two");
  claimed_low_a: assert property (
    rx_ok && !low[4] |=> store_valid && store_slot < 4'(ctf_pkg::CATCH_A))
    else $error("claimed message stored in catch-all slot");
  stamp_step_a: assert property (
    s.ts != $past(s.ts) |-> s.ts == $past(s.ts) + 16'h0001)
    else $error("stamp counter skipped a value");
  exit_active_a: assert property (
    wr && paddr[7:2] == ctf_pkg::OFF_CTRL[7:2] && pwdata[3] |=> !bus_off)
    else $error("bus off kept after forced exit");
  tx_follow_a: assert property (
    !s.ctrl.listen_only && !s.ctrl.init_mode |=> can_tx == $past(pe_tx_bit))
    else $error("engine bit not passed to the bus");
endmodule

/* File: test/ctf_bus_node.sv */
// model of another node on the bus, driving the receive line
`timescale 1ns/1ps
module ctf_bus_node (
  input  wire logic clock,
  output logic      can_rx
);
  // idle bus rests recessive, like the pulled-up wire
  initial begin
    can_rx = 1'b1;
  end

  // dominant for hold clocks after delay clocks, then recessive again
  task automatic fall(input int delay, input int hold);
    repeat (delay) @(posedge clock);
    can_rx <= 1'b0;
    repeat (hold) @(posedge clock);
    can_rx <= 1'b1;
  endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the timing, filter and time stamp block
`timescale 1ns/1ps
module tb_top;
  logic        clock, nrst, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, a;
  logic        pready, pslverr, can_rx, can_tx, pe_tx_bit, rx_ok, rx_ext;
  logic [28:0] rx_id;
  logic        rx_err_inc, tx_err_inc, bit_start, sample_point, rx_bit;
  logic        store_valid, pe_reinit, bus_off;
  logic [3:0]  store_slot;
  logic [15:0] store_stamp;
  int          n_fail, n_compared, n_reinit, n;

  ctf_top i_dut (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .can_rx(can_rx),
    .can_tx(can_tx), .pe_tx_bit(pe_tx_bit), .rx_ok(rx_ok), .rx_id(rx_id),
    .rx_ext(rx_ext), .rx_err_inc(rx_err_inc), .tx_err_inc(tx_err_inc),
    .bit_start(bit_start), .sample_point(sample_point), .rx_bit(rx_bit),
    .store_valid(store_valid), .store_slot(store_slot),
    .store_stamp(store_stamp), .pe_reinit(pe_reinit), .bus_off(bus_off));
  ctf_bus_node i_node (.clock(clock), .can_rx(can_rx));

  always #10 clock = ~clock;
  always @(posedge clock) begin
    if (pe_reinit === 1'b1) n_reinit <= n_reinit + 1;
  end

  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang();
    n_fail++;
    $display("CHECK FAILED wait expected event seen none");
    end_of_test();
  endtask

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  // request held until pready is sampled high, released only after
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask

  task automatic rdc(input string w, input logic [7:0] ad,
                     input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk(w, e, rd);
  endtask

  // edges until the chosen pulse is seen: 0 bit start, 1 sample point
  task automatic wait_pulse(input int sel, output int k);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while ((sel ? sample_point : bit_start) !== 1'b1 && k < 2000);
    if ((sel ? sample_point : bit_start) !== 1'b1) hang();
  endtask

  task automatic cfg(input logic [31:0] t, input logic [31:0] k);
    wr(ctf_pkg::OFF_CTRL, 32'h1);
    wr(ctf_pkg::OFF_TIMING, t);
    wr(ctf_pkg::OFF_CLKSEL, k);
    wr(ctf_pkg::OFF_CTRL, 32'h0);
    wait_pulse(0, n);
  endtask

  task automatic rx_case(input logic [28:0] id, input logic x, input int s);
    @(posedge clock);
    rx_ok <= 1'b1;
    rx_id <= id;
    rx_ext <= x;
    @(posedge clock);
    rx_ok <= 1'b0;
    @(posedge clock);
    chk("store_valid", (s < 16), store_valid);
    if (s < 16) chk("store_slot", s[3:0], store_slot);
  endtask

  task automatic t_reset();
    rdc("ctrl", ctf_pkg::OFF_CTRL, 32'h1);
    rdc("timing", ctf_pkg::OFF_TIMING, 32'h910);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped slverr", 32'h1, err);
    $display("test reset done");
  endtask

  task automatic t_timing();
    // prescaler 3, ten quanta: 60 clocks times the module divider
    for (int k = 0; k < 5; k++) begin
      cfg(32'h5a2, k);
      wait_pulse(0, n);
      chk("bit length", 60 << k, n);
    end
    cfg(32'h5af, 0);
    wait_pulse(0, n);
    chk("bit length brp15", 320, n);
    cfg(32'h910, 0);
    wait_pulse(1, n);
    chk("sync to sample", 12, n);
    wait_pulse(0, n);
    chk("sample to end", 6, n);
    $display("test timing done");
  endtask

  task automatic t_resync();
    wait_pulse(0, n);
    fork
      i_node.fall(3, 40);
    join_none
    wait_pulse(0, n);
    chk("late edge bit", 20, n);
    chk("sampled level", 32'h0, rx_bit);
    repeat (60) @(posedge clock);
    wait_pulse(0, n);
    fork
      i_node.fall(10, 40);
    join_none
    wait_pulse(0, n);
    chk("early edge bit", 16, n);
    repeat (60) @(posedge clock);
    // edge seen in the last quantum of phase two ends the bit there
    wait_pulse(0, n);
    fork
      i_node.fall(12, 40);
    join_none
    wait_pulse(0, n);
    chk("last quantum edge bit", 18, n);
    repeat (60) @(posedge clock);
    $display("test resync done");
  endtask

  task automatic t_filter();
    wr(ctf_pkg::OFF_GMASK, 32'h1ffffff0);
    wr(ctf_pkg::OFF_LMASK_A, 32'h700);
    wr(ctf_pkg::OFF_LMASK_B, 32'h7ff);
    wr(ctf_pkg::OFF_IDFMT, 32'h10);
    wr(ctf_pkg::OFF_SLOT, 32'h7f0);
    wr(ctf_pkg::OFF_SLOT + 8'h08, 32'h123);
    wr(ctf_pkg::OFF_SLOT + 8'h14, 32'h123);
    wr(ctf_pkg::OFF_SLOT + 8'h0c, 32'h450);
    wr(ctf_pkg::OFF_SLOT + 8'h10, 32'h1abcd450);
    wr(ctf_pkg::OFF_SLOT + 8'h38, 32'h200);
    wr(ctf_pkg::OFF_SLOT + 8'h3c, 32'h3ff);
    wr(ctf_pkg::OFF_RXEN, 32'hc03d);
    rx_case(29'h7f5, 1'b0, 0);
    rx_case(29'h123, 1'b0, 2);
    rx_case(29'h45a, 1'b0, 3);
    rx_case(29'h46a, 1'b0, 16);
    rx_case(29'h1abcd45f, 1'b1, 4);
    rx_case(29'h0bcd46f, 1'b1, 16);
    rx_case(29'h1abcd45f, 1'b0, 3);
    rx_case(29'h2ff, 1'b0, 14);
    rx_case(29'h3ff, 1'b0, 15);
    wr(ctf_pkg::OFF_AFS, 32'h0ab);
    rdc("filter port", ctf_pkg::OFF_AFS, 32'h1508);
    $display("test filter done");
  endtask

  task automatic t_alt();
    wr(ctf_pkg::OFF_CTRL, 32'h1);
    wr(ctf_pkg::OFF_CTRL, 32'h3);
    wr(ctf_pkg::OFF_LMASK_A, 32'h0);
    wr(ctf_pkg::OFF_LMASK_B, 32'h0);
    wr(ctf_pkg::OFF_SLOT + 8'h38, 32'h0);
    wr(ctf_pkg::OFF_SLOT + 8'h3c, 32'h0);
    wr(ctf_pkg::OFF_CTRL, 32'h2);
    rx_case(29'h555, 1'b0, 14);
    rx_case(29'h555, 1'b0, 15);
    rx_case(29'h555, 1'b0, 14);
    rx_case(29'h123, 1'b0, 2);
    rx_case(29'h555, 1'b0, 15);
    wr(ctf_pkg::OFF_CTRL, 32'h3);
    wr(ctf_pkg::OFF_CTRL, 32'h1);
    wr(ctf_pkg::OFF_CTRL, 32'h0);
    $display("test alternate done");
  endtask

  task automatic t_stamp();
    // eight bits is a whole number of stamp periods for every divider
    for (int d = 0; d < 4; d++) begin
      wr(ctf_pkg::OFF_CTRL, d << 4);
      wait_pulse(0, n);
      apb(1'b0, ctf_pkg::OFF_TS, 32'h0);
      a = rd;
      repeat (8) wait_pulse(0, n);
      apb(1'b0, ctf_pkg::OFF_TS, 32'h0);
      chk("stamp ticks", 8 >> d, (rd - a) & 32'hffff);
    end
    wait_pulse(0, n);
    repeat (4) @(posedge clock);
    rx_case(29'h123, 1'b0, 2);
    apb(1'b0, ctf_pkg::OFF_TS, 32'h0);
    chk("captured stamp", rd[15:0], store_stamp);
    $display("test stamp done");
  endtask

  task automatic t_listen();
    int bad;
    bad = 0;
    wr(ctf_pkg::OFF_CTRL, 32'h4);
    pe_tx_bit <= 1'b0;
    repeat (40) begin
      @(posedge clock);
      if (can_tx !== 1'b1) bad++;
    end
    chk("listen tx", 0, bad);
    rx_case(29'h123, 1'b0, 2);
    wr(ctf_pkg::OFF_CTRL, 32'h0);
    repeat (4) @(posedge clock);
    chk("driven tx", 32'h0, can_tx);
    pe_tx_bit <= 1'b1;
    $display("test listen done");
  endtask

  task automatic t_busoff();
    for (int i = 0; i < 256; i++) begin
      @(posedge clock);
      tx_err_inc <= 1'b1;
      rx_err_inc <= (i < 3);
    end
    @(posedge clock);
    tx_err_inc <= 1'b0;
    rx_err_inc <= 1'b0;
    rdc("error counts", ctf_pkg::OFF_ERR, 32'h30003);
    chk("bus off", 32'h1, bus_off);
    n_reinit = 0;
    wr(ctf_pkg::OFF_CTRL, 32'h8);
    repeat (3) @(posedge clock);
    chk("reinit pulses", 1, n_reinit);
    chk("bus off cleared", 32'h0, bus_off);
    rdc("counts cleared", ctf_pkg::OFF_ERR, 32'h0);
    rdc("timing kept", ctf_pkg::OFF_TIMING, 32'h910);
    rdc("slot kept", ctf_pkg::OFF_SLOT + 8'h08, 32'h123);
    rdc("mask kept", ctf_pkg::OFF_GMASK, 32'h1ffffff0);
    $display("test bus off done");
  endtask

  initial begin
    {clock, nrst, psel, penable, pwrite, rx_ok, rx_ext} = '0;
    {rx_err_inc, tx_err_inc, paddr, pwdata, rx_id} = '0;
    pe_tx_bit = 1'b1;
    n_fail = 0;
    n_compared = 0;
    n_reinit = 0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_timing();
    t_resync();
    t_filter();
    t_alt();
    t_stamp();
    t_listen();
    t_busoff();
    end_of_test();
  end
endmodule
